/* File: thermal_regs_defs.vh */
/*
 * register offsets, field positions and reset values of the feature report
 * and sensor settings registers.
 * assumes inclusion by bare name from the design files.
 */
`ifndef THERMAL_REGS_DEFS_VH
`define THERMAL_REGS_DEFS_VH

// ----------------------------------------
// pointer offsets
// ----------------------------------------
`define PTR_FEATURE_REPORT   4'h0
`define PTR_SENSOR_SETTINGS  4'h1

// ----------------------------------------
// feature report fields
// ----------------------------------------
`define FR_TRIPS_BIT         0
`define FR_PRECISION_BIT     1
`define FR_WIDE_RANGE_BIT    2
`define FR_RES_LO_BIT        3
`define FR_RES_HI_BIT        4
`define FR_TRIPS_VAL         1'h1
`define FR_PRECISION_VAL     1'h0
`define FR_WIDE_RANGE_VAL    1'h1
`define FR_RES_SIXTEENTH     2'h3
`define FR_RES_QUARTER       2'h1

// ----------------------------------------
// sensor settings fields
// ----------------------------------------
`define SS_MODE_BIT          0
`define SS_POL_BIT           1
`define SS_CRIT_ONLY_BIT     2
`define SS_OUT_EN_BIT        3
`define SS_STATUS_BIT        4
`define SS_CLEAR_BIT         5
`define SS_ALARM_LOCK_BIT    6
`define SS_CRIT_LOCK_BIT     7
`define SS_SHUTDOWN_BIT      8
`define SS_HYST_LO_BIT       9
`define SS_HYST_HI_BIT       10
`define SS_RESET_VAL         16'h0000

// ----------------------------------------
// hysteresis codes
// ----------------------------------------
`define HYST_OFF             2'h0
`define HYST_1P5             2'h1
`define HYST_3               2'h2
`define HYST_6               2'h3

`endif

/* File: reset_sync.v */
/*
 * two flip-flop release synchroniser for the active low reset.
 * assumes reset_n may fall at any time; release is taken on clk.
 */
`timescale 1ns/1ns
`default_nettype none

module reset_sync (
   input  wire clk,
   input  wire reset_n,
   output wire syncReset_n
);

   reg stage1_ff;
   reg stage2_ff;

   // ----------------------------------------
   // release chain
   // ----------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end else begin
         stage1_ff <= 1'b1;
         stage2_ff <= stage1_ff;
      end
   end

   assign syncReset_n = stage2_ff;

endmodule // reset_sync

`default_nettype wire

/* File: event_output.v */
/*
 * event pin logic: comparator or latched interrupt, polarity, enable.
 * assumes alarm and critical conditions are synchronous levels.
 */
`timescale 1ns/1ns
`default_nettype none

module event_output (
   input  wire clk,
   input  wire rst_n,
   input  wire alarmCond,
   input  wire critCond,
   input  wire intMode,
   input  wire activeHigh,
   input  wire critOnly,
   input  wire outEnable,
   input  wire shutdown,
   input  wire clearEvent,
   output wire eventActive,
   output reg  eventOut,
   output reg  eventOe
);

   reg  latched_ff;
   reg  nxt_latched;
   wire cause;

   // ----------------------------------------
   // event cause
   // ----------------------------------------
   // no new events while shut down; an interrupt latched before shutdown stays set
   assign cause = !shutdown && (critCond || (!critOnly && alarmCond));

   // ----------------------------------------
   // interrupt latch
   // ----------------------------------------
   always @* begin
      nxt_latched = latched_ff;
      if (!intMode)
         nxt_latched = 1'b0;
      else if (cause)
         nxt_latched = 1'b1;                  // set wins over clear
      else if (clearEvent && !critCond)
         nxt_latched = 1'b0;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         latched_ff <= 1'b0;
      else
         latched_ff <= nxt_latched;
   end

   // comparator follows cause, interrupt holds until cleared
   assign eventActive = outEnable && (intMode ? latched_ff : cause);

   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eventOut <= 1'b1;
         eventOe  <= 1'b0;
      end else begin
         eventOut <= activeHigh ? eventActive : !eventActive;
         eventOe  <= outEnable;
      end
   end

endmodule // event_output

`default_nettype wire

/* File: thermal_sensor_cap_config_regs.v */
/*
 * feature report and sensor settings register pair behind the serial
 * front end's pointer-addressed register port, plus the event pin.
 * assumes the serial front end issues one-cycle read and write strobes
 * with the pointer and a whole 16-bit word, synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "thermal_regs_defs.vh"

module thermal_sensor_cap_config_regs #(
   parameter PTR_W = 4
) (
   input  wire             clk,
   input  wire             reset_n,
   input  wire [PTR_W-1:0] regPtr,
   input  wire             regWrite,
   input  wire [15:0]      regWrData,
   input  wire             regRead,
   output reg  [15:0]      regRdData,
   output reg              regRdValid,
   output reg              regRdHit,
   input  wire             alarmCond,
   input  wire             critCond,
   output wire             eventOut,
   output wire             eventOe,
   output wire             alarmLock,
   output wire             critLock,
   output wire             shutdownMode,
   output wire [1:0]       hystSel
);

   wire        rst_n;
   wire        eventActive;
   wire [15:0] featureReport;
   wire [15:0] settingsView;
   wire        anyLock;
   wire        settingsWr;

   // settings flops
   reg         intMode_ff;
   reg         activeHigh_ff;
   reg         critOnly_ff;
   reg         outEnable_ff;
   reg         alarmLock_ff;
   reg         critLock_ff;
   reg         shutdown_ff;
   reg  [1:0]  hyst_ff;
   reg         clearEvent_ff;

   // next values
   reg         nxt_intMode;
   reg         nxt_activeHigh;
   reg         nxt_critOnly;
   reg         nxt_outEnable;
   reg         nxt_shutdown;
   reg         nxt_alarmLock;
   reg         nxt_critLock;
   reg  [1:0]  nxt_hyst;
   reg         nxt_clearEvent;
   reg  [15:0] nxt_rdData;
   reg         nxt_rdHit;

   localparam [15:0] SETTINGS_RST = `SS_RESET_VAL;

   // ----------------------------------------
   // pointer decode
   // ----------------------------------------
   function ptrIs;
      input [PTR_W-1:0] ptr;
      input [3:0]       target;
      reg   [PTR_W+3:0] wide;
      begin
         wide  = {4'h0, ptr};
         ptrIs = (wide == {{PTR_W{1'b0}}, target});
      end
   endfunction

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   // assert at once, release two edges later
   reset_sync uResetSync (
      .clk         (clk),
      .reset_n     (reset_n),
      .syncReset_n (rst_n)
   );

   // ----------------------------------------
   // feature report, all constant
   // ----------------------------------------
   // constant word, nothing stored
   assign featureReport = {11'h000,
                           `FR_RES_SIXTEENTH,
                           `FR_WIDE_RANGE_VAL,
                           `FR_PRECISION_VAL,
                           `FR_TRIPS_VAL};

   // ----------------------------------------
   // lock summary
   // ----------------------------------------
   // either lock freezes the event controls
   assign anyLock = alarmLock_ff || critLock_ff;

   // ----------------------------------------
   // settings write decode
   // ----------------------------------------
   // feature report has no write path
   assign settingsWr = regWrite && ptrIs(regPtr, `PTR_SENSOR_SETTINGS);

   // event controls
   always @* begin
      nxt_intMode    = intMode_ff;
      nxt_activeHigh = activeHigh_ff;
      nxt_critOnly   = critOnly_ff;
      nxt_outEnable  = outEnable_ff;
      if (settingsWr && !anyLock) begin
         nxt_intMode    = regWrData[`SS_MODE_BIT];
         nxt_activeHigh = regWrData[`SS_POL_BIT];
         nxt_critOnly   = regWrData[`SS_CRIT_ONLY_BIT];
         nxt_outEnable  = regWrData[`SS_OUT_EN_BIT];
      end
   end

   // shutdown may always be cleared, set only while unlocked
   always @* begin
      nxt_shutdown = shutdown_ff;
      if (settingsWr && (!anyLock || !regWrData[`SS_SHUTDOWN_BIT]))
         nxt_shutdown = regWrData[`SS_SHUTDOWN_BIT];
   end

   // locks only ever set; reset alone clears them
   always @* begin
      nxt_alarmLock = alarmLock_ff;
      nxt_critLock  = critLock_ff;
      if (settingsWr && regWrData[`SS_ALARM_LOCK_BIT])
         nxt_alarmLock = 1'b1;
      if (settingsWr && regWrData[`SS_CRIT_LOCK_BIT])
         nxt_critLock = 1'b1;
   end

   // hysteresis always open; clear is a one-cycle pulse
   always @* begin
      nxt_hyst       = hyst_ff;
      nxt_clearEvent = settingsWr && regWrData[`SS_CLEAR_BIT];
      if (settingsWr)
         nxt_hyst = regWrData[`SS_HYST_HI_BIT:`SS_HYST_LO_BIT];
   end

   // ----------------------------------------
   // event control storage
   // ----------------------------------------
   // enable resets off: pin undriven after power-on
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intMode_ff    <= SETTINGS_RST[`SS_MODE_BIT];
         activeHigh_ff <= SETTINGS_RST[`SS_POL_BIT];
         critOnly_ff   <= SETTINGS_RST[`SS_CRIT_ONLY_BIT];
         outEnable_ff  <= SETTINGS_RST[`SS_OUT_EN_BIT];
      end else begin
         intMode_ff    <= nxt_intMode;
         activeHigh_ff <= nxt_activeHigh;
         critOnly_ff   <= nxt_critOnly;
         outEnable_ff  <= nxt_outEnable;
      end
   end

   // ----------------------------------------
   // shutdown storage
   // ----------------------------------------
   // sensing runs after reset
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         shutdown_ff <= SETTINGS_RST[`SS_SHUTDOWN_BIT];
      else
         shutdown_ff <= nxt_shutdown;
   end

   // ----------------------------------------
   // lock storage
   // ----------------------------------------
   // only reset_n low clears a lock, at power-on or later
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alarmLock_ff <= SETTINGS_RST[`SS_ALARM_LOCK_BIT];
         critLock_ff  <= SETTINGS_RST[`SS_CRIT_LOCK_BIT];
      end else begin
         alarmLock_ff <= nxt_alarmLock;
         critLock_ff  <= nxt_critLock;
      end
   end

   // ----------------------------------------
   // hysteresis and clear pulse storage
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hyst_ff       <= SETTINGS_RST[`SS_HYST_HI_BIT:`SS_HYST_LO_BIT];
         clearEvent_ff <= SETTINGS_RST[`SS_CLEAR_BIT];
      end else begin
         hyst_ff       <= nxt_hyst;
         clearEvent_ff <= nxt_clearEvent;
      end
   end

   // ----------------------------------------
   // event pin
   // ----------------------------------------
   // status bit follows the gated event, not the pin
   event_output uEvent (
      .clk         (clk),
      .rst_n       (rst_n),
      .alarmCond   (alarmCond),
      .critCond    (critCond),
      .intMode     (intMode_ff),
      .activeHigh  (activeHigh_ff),
      .critOnly    (critOnly_ff),
      .outEnable   (outEnable_ff),
      .shutdown    (shutdown_ff),
      .clearEvent  (clearEvent_ff),
      .eventActive (eventActive),
      .eventOut    (eventOut),
      .eventOe     (eventOe)
   );

   // ----------------------------------------
   // settings read view
   // ----------------------------------------
   assign settingsView = {5'h00,
                          hyst_ff,
                          shutdown_ff,
                          critLock_ff,
                          alarmLock_ff,
                          1'b0,
                          eventActive,
                          outEnable_ff,
                          critOnly_ff,
                          activeHigh_ff,
                          intMode_ff};

   // ----------------------------------------
   // read select
   // ----------------------------------------
   // pointers other than the pair read zero, hit low
   // a write in the same cycle is not yet visible
   always @* begin
      nxt_rdData = regRdData;
      nxt_rdHit  = 1'b0;
      if (regRead) begin
         if (ptrIs(regPtr, `PTR_FEATURE_REPORT)) begin
            nxt_rdData = featureReport;
            nxt_rdHit  = 1'b1;
         end else if (ptrIs(regPtr, `PTR_SENSOR_SETTINGS)) begin
            nxt_rdData = settingsView;
            nxt_rdHit  = 1'b1;
         end else begin
            nxt_rdData = 16'h0000;
         end
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData  <= 16'h0000;
         regRdValid <= 1'b0;
         regRdHit   <= 1'b0;
      end else begin
         regRdData  <= nxt_rdData;
         regRdValid <= regRead;
         regRdHit   <= nxt_rdHit;
      end
   end

   // ----------------------------------------
   // settings exported to the sensor core
   // ----------------------------------------
   // locks also guard the trip limits outside
   assign alarmLock    = alarmLock_ff;
   assign critLock     = critLock_ff;
   assign shutdownMode = shutdown_ff;
   assign hystSel      = hyst_ff;

endmodule // thermal_sensor_cap_config_regs

`default_nettype wire

/* File: host_port_model.sv */
/* host side model of the register port: one-cycle write and read strobes.
   assumes the bench clock; strobes change 1 ns after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
   input  wire logic        clk,
   input  wire logic        rdValid,
   output var  logic [3:0]  ptr,
   output var  logic        wr,
   output var  logic [15:0] wrData,
   output var  logic        rd
);
   // ------------------------------
   // strobes
   // ------------------------------
   initial begin
      ptr = 4'h0;
      wr = 1'b0;
      wrData = 16'h0000;
      rd = 1'b0;
   end
   task automatic put(input logic [3:0] p, input logic [15:0] d);
      @(posedge clk);
      #1;
      ptr = p;
      wrData = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      wrData = ~d;
   endtask
   task automatic get(input logic [3:0] p, output logic ok);
      integer n;
      @(posedge clk);
      #1;
      ptr = p;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      ok = 1'b0;
      for (n = 0; n < 4 && !ok; n++) begin
         if (rdValid === 1'b1) ok = 1'b1;
         else begin
            @(posedge clk);
            #1;
         end
      end
   endtask
endmodule // host_port_model
`default_nettype wire

/* File: thermal_sensor_cap_config_regs_props.sv */
/* checker of the register pair at the top module's ports.
   assumes binding into the top module; reset_n low disables all. */
`timescale 1ns/1ns
`default_nettype none
module thermal_regs_checker #(parameter PTR_W = 4) (
   input wire logic             clk,
   input wire logic             reset_n,
   input wire logic [PTR_W-1:0] regPtr,
   input wire logic             regWrite,
   input wire logic [15:0]      regWrData,
   input wire logic             regRead,
   input wire logic [15:0]      regRdData,
   input wire logic             regRdValid,
   input wire logic             regRdHit,
   input wire logic             eventOe,
   input wire logic             alarmLock,
   input wire logic             critLock,
   input wire logic [1:0]       hystSel
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire lk = alarmLock || critLock;
   a_read_answer: assert property (regRead && regPtr < 2 |=> regRdValid && regRdHit)
      else $error("read not answered");
   a_feature_word: assert property (regRead && regPtr == 0 |=> regRdData == 16'h001d)
      else $error("feature word wrong");
   a_reserved_zero: assert property (regRdValid |-> regRdData[15:11] == 5'h00)
      else $error("reserved bits set");
   a_clear_reads: assert property (regRdValid |-> !regRdData[5])
      else $error("clear bit read high");
   a_lock_hold: assert property (alarmLock |=> alarmLock [*2])
      else $error("alarm lock dropped");
   a_crit_hold: assert property (critLock |=> critLock)
      else $error("critical lock dropped");
   a_lock_set: assert property (regWrite && regPtr == 1 && regWrData[7:6] == 2'h3
      |=> alarmLock && critLock)
      else $error("lock not set");
   a_oe_locked: assert property (lk ##1 lk |=> $stable(eventOe))
      else $error("enable moved under lock");
   a_oe_load: assert property (regWrite && regPtr == 1 && !lk
      |=> ##1 eventOe == $past(regWrData[3], 2))
      else $error("enable not loaded");
   a_hyst_load: assert property (regWrite && regPtr == 1 |=> hystSel == $past(regWrData[10:9]))
      else $error("hysteresis not loaded");
   a_feature_ro: assert property (regWrite && regPtr == 0 |=> $stable(hystSel) && $stable(eventOe))
      else $error("feature write had effect");
endmodule // thermal_regs_checker
bind thermal_sensor_cap_config_regs thermal_regs_checker #(.PTR_W(PTR_W)) checker_i (
   .clk(clk), .reset_n(reset_n), .regPtr(regPtr), .regWrite(regWrite),
   .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
   .regRdValid(regRdValid), .regRdHit(regRdHit), .eventOe(eventOe),
   .alarmLock(alarmLock), .critLock(critLock), .hystSel(hystSel));
`default_nettype wire

/* File: tb_thermal_sensor_cap_config_regs.sv */
/* self-checking bench of the feature report and settings registers.
   assumes host_port_model drives the register port. */
`timescale 1ns/1ns
`default_nettype none
module tb_thermal_sensor_cap_config_regs;
   logic clk, reset_n, regWrite, regRead, alarmCond, critCond;
   logic [3:0] regPtr;
   logic [15:0] regWrData, regRdData;
   logic regRdValid, regRdHit, eventOut, eventOe, alarmLock, critLock, shutdownMode;
   logic [1:0] hystSel;
   integer errTotal = 0;
   integer checks = 0;
   thermal_sensor_cap_config_regs thermal_sensor_cap_config_regs_i (.clk(clk),
      .reset_n(reset_n), .regPtr(regPtr), .regWrite(regWrite), .regWrData(regWrData),
      .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
      .regRdHit(regRdHit), .alarmCond(alarmCond), .critCond(critCond),
      .eventOut(eventOut), .eventOe(eventOe), .alarmLock(alarmLock),
      .critLock(critLock), .shutdownMode(shutdownMode), .hystSel(hystSel));
   host_port_model host_port_model_i (.clk(clk), .rdValid(regRdValid), .ptr(regPtr),
      .wr(regWrite), .wrData(regWrData), .rd(regRead));
   // ------------------------------
   // helpers
   // ------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic print_verdict;
      if (errTotal == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         errTotal++;
         $display("unexpected at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rdchk(input logic [3:0] p, input logic [15:0] e);
      logic ok;
      host_port_model_i.get(p, ok);
      if (!ok) begin
         errTotal++;
         print_verdict();
      end
      else check(regRdData, e);
   endtask
   task automatic wait3;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic do_reset;
      reset_n = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      reset_n = 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic s_feature;
      rdchk(4'h0, 16'h001d);
      host_port_model_i.put(4'h0, 16'hffe2);
      rdchk(4'h0, 16'h001d);
      rdchk(4'h1, 16'h0000);
      check({14'h0, eventOe, eventOut}, 16'h0001);
   endtask
   task automatic s_settings;
      integer i;
      host_port_model_i.put(4'h1, 16'hfe0f);
      rdchk(4'h1, 16'h060f);
      for (i = 0; i < 4; i++) begin
         host_port_model_i.put(4'h1, {5'h00, i[1:0], 9'h000});
         check({14'h0, hystSel}, i[15:0]);
      end
   endtask
   task automatic s_event;
      host_port_model_i.put(4'h1, 16'h000a);
      alarmCond = 1'b1;
      wait3();
      check({15'h0, eventOut}, 16'h0001);
      host_port_model_i.put(4'h1, 16'h000e);
      wait3();
      check({15'h0, eventOut}, 16'h0000);
      critCond = 1'b1;
      wait3();
      check({15'h0, eventOut}, 16'h0001);
      critCond = 1'b0;
      alarmCond = 1'b0;
      wait3();
      check({15'h0, eventOut}, 16'h0000);
      host_port_model_i.put(4'h1, 16'h000b);
      alarmCond = 1'b1;
      wait3();
      alarmCond = 1'b0;
      wait3();
      check({15'h0, eventOut}, 16'h0001);
      rdchk(4'h1, 16'h001b);
      host_port_model_i.put(4'h1, 16'h002b);
      wait3();
      check({15'h0, eventOut}, 16'h0000);
      rdchk(4'h1, 16'h000b);
   endtask
   task automatic s_lock;
      host_port_model_i.put(4'h1, 16'h01cb);
      rdchk(4'h1, 16'h01cb);
      host_port_model_i.put(4'h1, 16'h00c3);
      rdchk(4'h1, 16'h00cb);
      host_port_model_i.put(4'h1, 16'h0100);
      rdchk(4'h1, 16'h00cb);
      check({12'h0, shutdownMode, alarmLock, critLock, eventOe}, 16'h0007);
   endtask
   initial begin
      reset_n = 1'b0;
      alarmCond = 1'b0;
      critCond = 1'b0;
      do_reset();
      s_feature();
      s_settings();
      s_event();
      s_lock();
      do_reset();
      rdchk(4'h1, 16'h0000);
      print_verdict();
   end
endmodule // tb_thermal_sensor_cap_config_regs
`default_nettype wire
